//--- verilog/pafm_top.sv
// Port 1/3 alternate-function mux with its AHB-Lite register slave
// Function
// - P3.2 feeds irq zero, P3.3 irq one
// - Any peripheral source asserts irq zero
// - Irq one driven only by P3.3
// - P3.2 input never a general input
// - P3.2 usable as latch-driven output
// - P3.3 output, input, irq one, gate
// - Timer mode counts every twelve clocks
// - Counter mode counts pin falling edges
// - P3.3 level gates timer 1
// - No external gating for timer 0
// - P1.1 triggers capture or reload
// - Event pin general in timer mode or with its irq off
// - P1.1 general only when trigger off
// - External mode takes emulator strobes in
// - Internal mode outputs core strobes
// - P3.6/P3.7 never general I/O
// - Port 1 has no alternate output
// - Port 3 out is alternate AND latch, except P3.6/P3.7 held high and undriven in external mode
// - Irq pin counts only when enabled
`timescale 1ns/1ns
module pafm_top
    import pafm_pkg::*;
(
    input  wire logic        i_ref_clk,         // MCU clock, 20 MHz
    input  wire logic        i_srst,            // Sync reset, high
    input  wire logic        i_hsel,            // AHB slave select
    input  wire logic [31:0] i_haddr,           // AHB address
    input  wire logic [1:0]  i_htrans,          // AHB transfer type
    input  wire logic        i_hwrite,          // AHB write
    input  wire logic [2:0]  i_hsize,           // AHB size
    input  wire logic [31:0] i_hwdata,          // AHB write data
    input  wire logic        i_hready,          // AHB bus ready
    output logic      [31:0] o_hrdata,          // AHB read data
    output logic             o_hreadyout,       // AHB slave ready
    output logic      [1:0]  o_hresp,           // AHB response
    input  wire logic [7:2]  i_port3_din,       // Port 3 pad inputs
    output logic      [7:2]  o_port3_dout,      // Port 3 pad outputs
    output logic      [7:2]  o_port3_oe,        // Port 3 drive enables
    input  wire logic [1:0]  i_port1_din,       // Port 1 pad inputs
    output logic      [1:0]  o_port1_dout,      // Port 1 pad outputs
    output logic      [1:0]  o_port1_oe,        // Port 1 drive enables
    input  wire logic [7:0]  i_periph_irq,      // On-chip irq sources
    input  wire logic        i_core_wr_strobe_n, // Core write strobe
    input  wire logic        i_core_rd_strobe_n, // Core read strobe
    output logic             o_core_irq_zero_n, // Core irq zero, low
    output logic             o_core_irq_one_n,  // Core irq one, low
    output logic      [2:0]  o_timer_inc,       // Timer count pulses
    output logic             o_timer2_capture,  // Timer 2 capture pulse
    output logic             o_timer2_reload,   // Timer 2 reload pulse
    output logic             o_ext_rd_strobe_n, // Emulator read strobe
    output logic             o_ext_wr_strobe_n  // Emulator write strobe
);

    // Whole block state in one word
    typedef struct packed {
        logic [12:0] ctrl;      // Control register
        logic [9:2]  latch;     // Port latches
        logic        wr_pend;   // Write data phase pending
        logic [7:0]  wr_addr;   // Pending write offset
        logic [31:0] hrdata;    // Read data
        logic        hready;    // Ready out
        logic [3:0]  pre;       // Machine cycle prescaler
        logic        tick;      // Machine cycle pulse
        logic [3:0]  smp;       // Pin samples at last tick
        logic        irq0_n;    // Irq zero out
        logic        irq1_n;    // Irq one out
        logic [2:0]  tinc;      // Timer count pulses
        logic        t2_cap;    // Capture pulse
        logic        t2_rld;    // Reload pulse
        logic        ext_rd_n;  // Emulator read strobe
        logic        ext_wr_n;  // Emulator write strobe
        logic [7:2]  p3_dout;   // Port 3 outputs
        logic [7:2]  p3_oe;     // Port 3 enables
        logic [1:0]  p1_dout;   // Port 1 outputs
        logic [1:0]  p1_oe;     // Port 1 enables
    } pafm_top_state_type;

    pafm_top_state_type     r;       // Current state
    pafm_top_state_type     next_r;  // Next state
    logic [PAFM_PINS-1:0]   pins;    // Synchronised pins

    // Pads are asynchronous to the core clock
    pafm_sync u_sync (
        .i_ref_clk (i_ref_clk),
        .i_srst    (i_srst),
        .i_async   ({i_port3_din, i_port1_din}),
        .o_sync    (pins)
    );

    // Named views of the synchronised pins
    logic       pin32;    // Irq pin
    logic       pin33;    // Irq one and gate
    logic       pin36;    // Emulator write
    logic       pin37;    // Emulator read
    logic [3:0] evt;      // Event/trigger pins
    assign pin32 = pins[2];
    assign pin33 = pins[3];
    assign pin36 = pins[6];
    assign pin37 = pins[7];
    // Order: timer0, timer1, timer2 event, timer2 trigger
    assign evt   = {pins[1], pins[0], pins[5], pins[4]};

    // Control fields
    logic       ext;       // External cpu select
    logic       xen;       // Irq pin enable
    logic [2:0] tsel;      // Counter mode per timer
    logic [2:0] run;       // Run per timer
    logic       gate1;     // Timer 1 gate enable
    logic       t2ex;      // Timer 2 trigger enable
    logic [2:0] tie;       // Timer irq enables
    assign ext   = r.ctrl[PAFM_CTRL_EXT];
    assign xen   = r.ctrl[PAFM_CTRL_XEN];
    assign tsel  = r.ctrl[PAFM_CTRL_TSEL +: 3];
    assign run   = r.ctrl[PAFM_CTRL_RUN +: 3];
    assign gate1 = r.ctrl[PAFM_CTRL_GATE1];
    assign t2ex  = r.ctrl[PAFM_CTRL_T2EX];
    assign tie   = r.ctrl[PAFM_CTRL_TIE +: 3];

    // Bus address phase accepted this cycle
    // Narrow sizes never qualify, so a byte write cannot land
    logic acc;
    assign acc = i_hsel && i_htrans[1] && i_hready && (i_hsize == PAFM_HSIZE_WORD);

    // Edges seen only on machine cycle samples
    logic [3:0] fall;      // Falling edge per event pin
    logic [2:0] live;      // Timer allowed to count
    logic [7:2] alt;       // Port 3 alternate outputs
    logic [7:2] gpin;      // Port 3 general input view
    logic [1:0] gpin1;     // Port 1 general input view
    logic [31:0] stat;     // Status word

    // Whole next state
    always_comb begin
        next_r = r;
        // Machine cycle prescaler
        // Free-running: a timer started mid-cycle waits up to eleven clocks
        if (r.pre == PAFM_MCYC_LAST) begin
            next_r.pre = 4'h0;
        end else begin
            next_r.pre = r.pre + 4'h1;
        end
        next_r.tick = (r.pre == PAFM_MCYC_LAST);
        // A level must sit across a full tick gap to be seen
        fall = {4{r.tick}} & r.smp & ~evt;
        if (r.tick) begin
            next_r.smp = evt;
        end
        // Timer 0 runs ungated: its gate pin is taken by irq zero
        live[0] = run[0];
        live[1] = run[1] && (!gate1 || pin33);
        live[2] = run[2];
        for (int i = 0; i < 3; i++) begin
            next_r.tinc[i] = live[i] && (tsel[i] ? fall[i] : r.tick);
        end
        // Trigger: capture when counting, reload when timing
        next_r.t2_cap = t2ex && fall[3] && tsel[2];
        next_r.t2_rld = t2ex && fall[3] && !tsel[2];
        // Irq zero merges peripherals with the enabled pin
        next_r.irq0_n = !((|i_periph_irq) || (xen && !pin32));
        next_r.irq1_n = pin33;
        // Strobe routing by processor mode
        next_r.ext_rd_n = ext ? pin37 : 1'b1;
        next_r.ext_wr_n = ext ? pin36 : 1'b1;
        alt = 6'h3F;
        if (!ext) begin
            alt[6] = i_core_wr_strobe_n;
            alt[7] = i_core_rd_strobe_n;
        end
        next_r.p3_dout = alt & r.latch[7:2];
        // Open-drain style: drive only lows on general bits
        next_r.p3_oe = ~next_r.p3_dout;
        if (ext) begin
            next_r.p3_dout[7:6] = 2'h3;
            next_r.p3_oe[7:6]   = 2'h0;
        end else begin
            next_r.p3_oe[7:6]   = 2'h3;
        end
        next_r.p1_dout = r.latch[9:8];
        next_r.p1_oe   = ~r.latch[9:8];
        // General input views
        // A blocked view reads 0 so firmware never trusts a taken pin
        gpin[2] = 1'b0;
        gpin[3] = pin33;
        gpin[4] = (!tsel[0] || !tie[0]) ? pins[4] : 1'b0;
        gpin[5] = (!tsel[1] || !tie[1]) ? pins[5] : 1'b0;
        gpin[7:6] = 2'h0;
        gpin1[0] = (!tsel[2] || !tie[2]) ? pins[0] : 1'b0;
        gpin1[1] = !t2ex ? pins[1] : 1'b0;
        // Data phase write lands now
        if (r.wr_pend) begin
            case (r.wr_addr)
                PAFM_OFS_CTRL: begin
                    next_r.ctrl = i_hwdata[PAFM_CTRL_W-1:0];
                end
                PAFM_OFS_LATCH: begin
                    next_r.latch = i_hwdata[PAFM_LATCH_HI:PAFM_LATCH_LO];
                end
                default: begin
                    next_r.wr_pend = 1'b0;  // Unmapped: ignored
                end
            endcase
        end
        // Write offset is held over into the data phase
        next_r.wr_pend = acc && i_hwrite;
        next_r.wr_addr = i_haddr[7:0];
        // Status word
        stat = 32'h0000_0000;
        stat[7:2] = gpin;
        stat[PAFM_LATCH_P1 +: 2] = gpin1;
        stat[PAFM_STAT_IRQ0] = !r.irq0_n;
        stat[PAFM_STAT_IRQ1] = !r.irq1_n;
        stat[PAFM_STAT_EXT]  = ext;
        // Read from next values so a write just before is seen
        if (acc && !i_hwrite) begin
            case (i_haddr[7:0])
                PAFM_OFS_CTRL: begin
                    next_r.hrdata = {19'h0_0000, next_r.ctrl};
                end
                PAFM_OFS_LATCH: begin
                    next_r.hrdata = {22'h00_0000, next_r.latch, 2'h0};
                end
                PAFM_OFS_STAT: begin
                    next_r.hrdata = stat;
                end
                default: begin
                    next_r.hrdata = 32'h0000_0000;
                end
            endcase
        end
        next_r.hready = 1'b1;  // No wait states ever
        // Reset image
        // Event samples reset high so a pin still low at the first tick after reset gives a fall
        if (i_srst) begin
            next_r          = '0;
            next_r.ctrl     = PAFM_CTRL_RST;
            next_r.latch    = PAFM_LATCH_RST;
            next_r.hready   = 1'b1;
            next_r.smp      = 4'hF;
            next_r.irq0_n   = 1'b1;
            next_r.irq1_n   = 1'b1;
            next_r.ext_rd_n = 1'b1;
            next_r.ext_wr_n = 1'b1;
            next_r.p3_dout  = 6'h3F;
            next_r.p1_dout  = 2'h3;
        end
    end

    // State register
    always_ff @(posedge i_ref_clk) begin
        r <= next_r;
    end

    // Outputs straight from state, hresp fixed at OKAY
    assign o_hrdata          = r.hrdata;
    assign o_hreadyout       = r.hready;
    assign o_hresp           = PAFM_HRESP_OKAY;
    assign o_port3_dout      = r.p3_dout;
    assign o_port3_oe        = r.p3_oe;
    assign o_port1_dout      = r.p1_dout;
    assign o_port1_oe        = r.p1_oe;
    assign o_core_irq_zero_n = r.irq0_n;
    assign o_core_irq_one_n  = r.irq1_n;
    assign o_timer_inc       = r.tinc;
    assign o_timer2_capture  = r.t2_cap;
    assign o_timer2_reload   = r.t2_rld;
    assign o_ext_rd_strobe_n = r.ext_rd_n;
    assign o_ext_wr_strobe_n = r.ext_wr_n;

    // Checks, all on the one clock
    default clocking cb @(posedge i_ref_clk);
    endclocking
    default disable iff (i_srst);

    // Interrupt routing
    chk_irq_one_pin:
    assert property (o_core_irq_one_n == $past(pin33))
        else $error("irq one does not follow its pin");

    chk_irq_zero_periph:
    assert property ((|i_periph_irq) |=> !o_core_irq_zero_n)
        else $error("peripheral irq lost on irq zero");

    chk_irq_pin_gated:
    assert property ((!xen && i_periph_irq == 8'h00) |=> o_core_irq_zero_n)
        else $error("disabled irq pin reached irq zero");

    // Timer pacing: eleven quiet clocks, then the next tick
    chk_tick_period:
    assert property (r.tick |=> (!r.tick)[*8] ##1 (!r.tick)[*3] ##1 r.tick)
        else $error("machine cycle is not twelve clocks");

    chk_timer_mode:
    assert property ((r.tick && run[0] && !tsel[0]) |=> o_timer_inc[0])
        else $error("timer 0 missed a machine cycle");

    chk_gate_closed:
    assert property ((gate1 && !pin33) |=> !o_timer_inc[1])
        else $error("timer 1 counted with gate low");

    // Pad routing
    chk_p32_latch:
    assert property (o_port3_dout[2] == $past(r.latch[2]))
        else $error("port3 bit2 output not its latch");

    chk_strobe_out:
    assert property (!ext |=> (o_port3_dout[6] == ($past(i_core_wr_strobe_n)
                     && $past(r.latch[6])) && o_port3_oe[6]))
        else $error("core write strobe not on port3 bit6");

    chk_strobe_in:
    assert property (ext |=> (o_port3_oe[7:6] == 2'h0))
        else $error("strobe pins driven in external mode");

    chk_port1_plain:
    assert property (o_port1_dout == $past(r.latch[9:8]))
        else $error("port 1 output not its latch");

    // Emulator strobes follow their pins one clock late
    chk_emul_strobes:
    assert property (ext |=> (o_ext_rd_strobe_n == $past(pin37)
                     && o_ext_wr_strobe_n == $past(pin36)))
        else $error("emulator strobes not routed from pins");

    chk_emul_idle:
    assert property (!ext |=> (o_ext_rd_strobe_n && o_ext_wr_strobe_n))
        else $error("emulator strobes active in internal mode");

    chk_strobe_rd_out:
    assert property (!ext |=> (o_port3_dout[7] == ($past(i_core_rd_strobe_n)
                     && $past(r.latch[7])) && o_port3_oe[7]))
        else $error("core read strobe not on port3 bit7");

    // Trigger and run gating
    chk_trig_off:
    assert property (!t2ex |=> (!o_timer2_capture && !o_timer2_reload))
        else $error("trigger pulse with trigger disabled");

    chk_timer_stopped:
    assert property ((run == 3'h0) |=> (o_timer_inc == 3'h0))
        else $error("timer pulse while stopped");

endmodule

//--- verilog/pafm_pkg.sv
// Constants shared by the port alternate-function mux files
package pafm_pkg;

    // Register byte offsets (low address byte)
    localparam logic [7:0]  PAFM_OFS_CTRL  = 8'h00;
    localparam logic [7:0]  PAFM_OFS_LATCH = 8'h04;
    localparam logic [7:0]  PAFM_OFS_STAT  = 8'h08;

    // Control register field positions
    localparam int          PAFM_CTRL_EXT   = 0;   // External cpu select
    localparam int          PAFM_CTRL_XEN   = 1;   // External irq pin enable
    localparam int          PAFM_CTRL_TSEL  = 2;   // Timer/counter select, 3 bits
    localparam int          PAFM_CTRL_RUN   = 5;   // Timer run, 3 bits
    localparam int          PAFM_CTRL_GATE1 = 8;   // Timer 1 gate enable
    localparam int          PAFM_CTRL_T2EX  = 9;   // Timer 2 trigger enable
    localparam int          PAFM_CTRL_TIE   = 10;  // Timer irq enable, 3 bits
    localparam int          PAFM_CTRL_W     = 13;  // Control width

    // Latch register: port 3 bits 7..2 at word bits 7..2, port 1 at 9..8
    localparam int          PAFM_LATCH_LO  = 2;
    localparam int          PAFM_LATCH_HI  = 9;
    localparam int          PAFM_LATCH_P1  = 8;

    // Status register field positions
    localparam int          PAFM_STAT_IRQ0 = 10;
    localparam int          PAFM_STAT_IRQ1 = 11;
    localparam int          PAFM_STAT_EXT  = 12;

    // Reset values
    localparam logic [12:0] PAFM_CTRL_RST  = 13'h0000;
    localparam logic [9:2]  PAFM_LATCH_RST = 8'hFF;

    // Machine cycle length in MCU clocks
    localparam int          PAFM_MCYC_CLKS = 12;
    localparam logic [3:0]  PAFM_MCYC_LAST = 4'(PAFM_MCYC_CLKS - 1);

    // Bus encodings
    localparam logic [2:0]  PAFM_HSIZE_WORD = 3'h2;
    localparam logic [1:0]  PAFM_HRESP_OKAY = 2'h0;

    // Synchronised pin vector width: port 3 bits 7..2, port 1 bits 1..0
    localparam int          PAFM_PINS      = 8;

endpackage

//--- verilog/pafm_sync.sv
// Two-stage synchroniser for the port pin inputs
`timescale 1ns/1ns
module pafm_sync
    import pafm_pkg::*;
(
    input  wire logic                 i_ref_clk,  // MCU clock
    input  wire logic                 i_srst,     // Sync reset, high
    input  wire logic [PAFM_PINS-1:0] i_async,    // Raw pad inputs
    output logic      [PAFM_PINS-1:0] o_sync      // Synchronised inputs
);

    // Both stages in one state word
    typedef struct packed {
        logic [PAFM_PINS-1:0] meta;  // First stage, read only by second
        logic [PAFM_PINS-1:0] safe;  // Second stage
    } pafm_sync_state_type;

    pafm_sync_state_type r;       // Current state
    pafm_sync_state_type next_r;  // Next state

    // Shift; idle pins rest high like the pullups
    always_comb begin
        next_r.meta = i_async;
        next_r.safe = r.meta;
        if (i_srst) begin
            next_r.meta = '1;
            next_r.safe = '1;
        end
    end

    // State register
    always_ff @(posedge i_ref_clk) begin
        r <= next_r;
    end

    assign o_sync = r.safe;

endmodule

//--- bench/pafm_pin_model.sv
// Pad wire model: pull-ups, external pull-downs and one event source
`timescale 1ns/1ns
module pafm_pin_model (
    input  wire logic       i_ref_clk,  // MCU clock
    input  wire logic [7:2] i_p3_dout,  // Design port 3 value
    input  wire logic [7:2] i_p3_oe,    // Design port 3 enable
    input  wire logic [1:0] i_p1_dout,  // Design port 1 value
    input  wire logic [1:0] i_p1_oe,    // Design port 1 enable
    input  wire logic [7:2] i_p3_low,   // Outside pull-down, port 3
    input  wire logic [1:0] i_p1_low,   // Outside pull-down, port 1
    input  wire logic       i_evt_en,   // Event source running
    output logic      [7:2] o_p3_pin,   // Resolved port 3 wires
    output logic      [1:0] o_p1_pin    // Resolved port 1 wires
);
    logic [3:0] half_cnt;  // Clocks spent in this level
    logic       evt_lvl;   // Event source level

    initial begin
        half_cnt = 4'h0;
        evt_lvl = 1'b1;
    end

    // Each level held 13 clocks; stops only when high, so no runt pulse
    always @(posedge i_ref_clk) begin
        if (i_evt_en || !evt_lvl) begin
            half_cnt <= (half_cnt == 4'hC) ? 4'h0 : half_cnt + 4'h1;
            if (half_cnt == 4'hC) begin
                evt_lvl <= ~evt_lvl;
            end
        end
    end

    // Driven wire follows the design, a released one the pull-up
    always_comb begin
        o_p3_pin = (i_p3_oe & i_p3_dout) | (~i_p3_oe & ~i_p3_low);
        o_p3_pin[5:4] = o_p3_pin[5:4] & {2{evt_lvl}};
        o_p1_pin = ((i_p1_oe & i_p1_dout) | (~i_p1_oe & ~i_p1_low)) & {2{evt_lvl}};
    end
endmodule

//--- bench/pafm_tb_top.sv
// Self-checking bench for the port alternate-function mux
`timescale 1ns/1ns
module pafm_tb_top import pafm_pkg::*;;
    localparam logic [31:0] A_CTRL = {24'h00_0000, PAFM_OFS_CTRL};
    localparam logic [31:0] A_LAT  = {24'h00_0000, PAFM_OFS_LATCH};
    localparam logic [31:0] A_STAT = {24'h00_0000, PAFM_OFS_STAT};

    // One table row: stimulus, then the port and status it should give
    typedef struct packed {
        logic [12:0] ctrl;   // Control word
        logic [9:0]  lat;    // Latch word
        logic [5:0]  lo3;    // Port 3 pulled low
        logic [7:0]  irq;    // Peripheral sources
        logic [1:0]  strb;   // Core strobes, write then read
        logic [19:0] pads;   // Port and line outputs
        logic [12:0] st;     // Status word
    } pafm_row_type;

    logic        clk, srst, hsel, hwrite, hrdy, irq0_n, irq1_n;
    logic        wr_n, rd_n, cap, rel, ext_rd_n, ext_wr_n, evt_en;
    logic [31:0] haddr, hwdata, hrdata, tmp;
    logic [1:0]  htrans, hresp, p1_din, p1_dout, p1_oe, p1_low;
    logic [2:0]  hsize, tinc;
    logic [7:2]  p3_din, p3_dout, p3_oe, p3_low;
    logic [7:0]  irq;
    logic [3:0]  prev_ev;       // Event pins last clock
    logic [3:0]  cur_ev;        // Event pins this clock
    int          n_errors, num_checks, counting, n;
    int          cnt [9];       // Pulses 0..4, pin falls 5..8
    pafm_row_type rows [7] = '{
        '{13'h0000, 10'h3FC, 6'h00, 8'h00, 2'h3, 20'hFF_0CF, 13'h0338},
        '{13'h0000, 10'h3FC, 6'h03, 8'h00, 2'h1, 20'hBF_0CB, 13'h0B30},
        '{13'h0002, 10'h3FC, 6'h01, 8'h00, 2'h3, 20'hFF_0C7, 13'h0738},
        '{13'h0000, 10'h3FC, 6'h00, 8'h80, 2'h2, 20'h7F_0C7, 13'h0738},
        '{13'h0001, 10'h3FC, 6'h30, 8'h00, 2'h0, 20'hFC_0CC, 13'h1338},
        '{13'h0000, 10'h2E8, 6'h00, 8'h00, 2'h3, 20'hEB_59F, 13'h0228},
        '{13'h1614, 10'h3FC, 6'h00, 8'h00, 2'h3, 20'hFF_0CF, 13'h0028}
    };

    pafm_top uut (
        .i_ref_clk(clk), .i_srst(srst), .i_hsel(hsel), .i_haddr(haddr),
        .i_htrans(htrans), .i_hwrite(hwrite), .i_hsize(hsize), .i_hwdata(hwdata),
        .i_hready(hrdy), .o_hrdata(hrdata), .o_hreadyout(hrdy), .o_hresp(hresp),
        .i_port3_din(p3_din), .o_port3_dout(p3_dout), .o_port3_oe(p3_oe),
        .i_port1_din(p1_din), .o_port1_dout(p1_dout), .o_port1_oe(p1_oe),
        .i_periph_irq(irq), .i_core_wr_strobe_n(wr_n), .i_core_rd_strobe_n(rd_n),
        .o_core_irq_zero_n(irq0_n), .o_core_irq_one_n(irq1_n), .o_timer_inc(tinc),
        .o_timer2_capture(cap), .o_timer2_reload(rel),
        .o_ext_rd_strobe_n(ext_rd_n), .o_ext_wr_strobe_n(ext_wr_n)
    );

    pafm_pin_model pads (
        .i_ref_clk(clk), .i_p3_dout(p3_dout), .i_p3_oe(p3_oe), .i_p1_dout(p1_dout),
        .i_p1_oe(p1_oe), .i_p3_low(p3_low), .i_p1_low(p1_low), .i_evt_en(evt_en),
        .o_p3_pin(p3_din), .o_p1_pin(p1_din)
    );

    // Free-running MCU clock
    initial begin
        clk = 1'b0;
        forever #25 clk = ~clk;
    end

    // Order: timer0, timer1, timer2 event, timer2 trigger
    assign cur_ev = {p1_din, p3_din[5:4]};

    // Pulse and pin-fall counters, open only inside a counting window
    always @(posedge clk) begin
        prev_ev <= cur_ev;
        if (counting != 0) begin
            for (int i = 0; i < 3; i++) cnt[i] += int'(tinc[i]);
            cnt[3] += int'(cap);
            cnt[4] += int'(rel);
            for (int i = 0; i < 4; i++) cnt[5 + i] += int'(prev_ev[i] & ~cur_ev[i]);
        end
    end

    task automatic report_and_stop;
        $display("Checks %0d, mismatches %0d", num_checks, n_errors);
        if (n_errors == 0 && num_checks > 0) begin
            $display("Finished cleanly");
        end else begin
            $display("Finished with errors");
        end
        $finish;
    endtask

    task automatic cmp(input logic [31:0] got, input logic [31:0] exp, input string what);
        num_checks++;
        if (got !== exp) begin
            n_errors++;
            $display("MISMATCH t=%0t %s got %h exp %h", $time, what, got, exp);
        end
    endtask

    // One single word transfer; waits on ready, never on a cycle count
    task automatic ahb(input logic w, input logic [31:0] a, input logic [31:0] d,
                       output logic [31:0] r);
        @(posedge clk);
        hsel   <= 1'b1;
        haddr  <= a;
        hwrite <= w;
        htrans <= 2'h2;
        @(posedge clk);
        while (hrdy !== 1'b1) @(posedge clk);
        hsel   <= 1'b0;
        htrans <= 2'h0;
        hwdata <= d;
        @(posedge clk);
        while (hrdy !== 1'b1) @(posedge clk);
        r = hrdata;
        cmp({30'h0, hresp}, {30'h0, PAFM_HRESP_OKAY}, "hresp");
    endtask

    task automatic wr(input logic [31:0] a, input logic [31:0] d);
        ahb(1'b1, a, d, tmp);
    endtask

    task automatic cmp_reg(input logic [31:0] a, input logic [31:0] exp);
        logic [31:0] got;
        ahb(1'b0, a, 32'h0000_0000, got);
        cmp(got, exp, "register read");
    endtask

    // Output levels held while reset is applied
    task automatic chk_rst;
        cmp({4'h0, hrdy, hresp, p3_dout, p3_oe, p1_dout, p1_oe, irq0_n, irq1_n, tinc,
             cap, rel, ext_rd_n, ext_wr_n}, 32'h09F8_1983, "reset outputs");
        cmp(hrdata, 32'h0000_0000, "reset read data");
    endtask

    // Runs the event source under one mode, counters cleared first
    task automatic run_events(input logic [31:0] ctrl, input logic [5:0] lo3);
        wr(A_CTRL, ctrl);
        p3_low <= lo3;
        cnt = '{default: 0};
        counting = 1;
        evt_en <= 1'b1;
        repeat (156) @(posedge clk);
        evt_en <= 1'b0;
        repeat (60) @(posedge clk);
        counting = 0;
    endtask

    // Hang guard, far beyond the few hundred clocks of the run
    initial begin
        repeat (8000) @(posedge clk);
        n_errors++;
        report_and_stop();
    end

    initial begin
        {srst, hsel, hwrite, htrans, haddr, hwdata, evt_en} = '0;
        {p3_low, p1_low, irq, counting} = '0;
        {wr_n, rd_n} = 2'h3;
        hsize = PAFM_HSIZE_WORD;
        srst = 1'b1;
        repeat (8) @(posedge clk);
        chk_rst();
        srst <= 1'b0;
        cmp_reg(A_CTRL, 32'h0000_0000);
        cmp_reg(A_LAT, 32'h0000_03FC);
        cmp_reg(A_STAT, 32'h0000_0338);
        wr(A_STAT, 32'hFFFF_FFFF);
        cmp_reg(A_STAT, 32'h0000_0338);
        wr(32'h0000_000C, 32'hFFFF_FFFF);
        cmp_reg(32'h0000_000C, 32'h0000_0000);
        $display("Test reset and map done");
        foreach (rows[i]) begin
            @(posedge clk);
            p3_low <= rows[i].lo3;
            irq <= rows[i].irq;
            {wr_n, rd_n} <= rows[i].strb;
            wr(A_CTRL, {19'h0, rows[i].ctrl});
            wr(A_LAT, {22'h0, rows[i].lat});
            repeat (6) @(posedge clk);
            cmp({12'h0, p3_dout, p3_oe, p1_dout, p1_oe, irq0_n, irq1_n, ext_rd_n, ext_wr_n},
                {12'h0, rows[i].pads}, "pads");
            cmp_reg(A_STAT, {19'h0, rows[i].st});
        end
        {wr_n, rd_n, irq} <= 10'h300;
        $display("Test table done");
        run_events(32'h0000_03FC, 6'h03);
        cmp(cnt[0], cnt[5], "timer 0 counts");
        cmp(cnt[5] > 3, 1, "events seen");
        cmp(cnt[1], 0, "timer 1 gated");
        cmp(cnt[2], cnt[7], "timer 2 counts");
        cmp(cnt[3], cnt[8], "captures");
        cmp(cnt[4], 0, "no reload");
        run_events(32'h0000_03EC, 6'h00);
        cmp(cnt[1], cnt[6], "timer 1 open");
        cmp(cnt[4], cnt[8], "reloads");
        cmp(cnt[3], 0, "no capture");
        $display("Test events done");
        wr(A_CTRL, 32'h0000_00E0);
        n = 0;
        while (tinc[0] !== 1'b1 && n < 30) begin
            @(posedge clk);
            n++;
        end
        n = 0;
        do begin
            @(posedge clk);
            n++;
        end while (tinc[0] !== 1'b1 && n < 30);
        cmp(n, 12, "machine cycle");
        srst <= 1'b1;
        repeat (8) @(posedge clk);
        chk_rst();
        srst <= 1'b0;
        cmp_reg(A_CTRL, 32'h0000_0000);
        $display("Test timer and second reset done");
        report_and_stop();
    end
endmodule
